// ==== hdl/burst_memory.sv ====
/*
  Device end: a synchronous burst memory with configurable latency,
  burst length, burst type and wait polarity, holding a small array.
  Assumes the host keeps its own obligations and all pins are synchronous.
*/
// Notes on behaviour
// R1 - Address latched at first valid command edge.
// R2 - Write enable level picks read or write.
// R3 - Host selects chip before address latch.
// R4 - Read: clock edge with valid and select low.
// R5 - Later edges under held valid are ignored.
// R6 - First read word after latency count.
// R7 - Write: valid, write enable, select low.
// R8 - First write word captured at latency.
// R9 - Everything timed on the rising clock.
// R10 - Latency count sets first-word delay.
// R11 - Lengths four, eight, sixteen, 256 words.
// R12 - Host keeps full-page bursts within limit.
// R13 - Following read words one clock apart.
// R14 - Chip select high stops burst at once.
// R15 - Host issues no command mid-burst.
// R16 - Wait indicator level follows polarity setting.
// R17 - Wait active one clock before data.
// R18 - First word exact; later waits allowed.
// R19 - Linear order wraps in aligned block.
// R20 - Interleave uses start XOR counter.
// R21 - Full page is linear only, wrapping.
// R22 - Configuration word field positions.
// R23 - Burst mode only when mode field synchronous.
`timescale 1ns/1ps
module burst_memory #(
  parameter int DEPTH_W = 10
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic [burst_pkg::CFG_W-1:0] configWord,
  burst_if.memory                          link
);
  import burst_pkg::*;

  logic [DATA_W-1:0]  mem [0:(1<<DEPTH_W)-1];
  burst_state_e       state;
  logic [LAT_W-1:0]   latCount;
  logic [7:0]         beat;
  logic [7:0]         startLow;
  logic [ADDR_W-1:0]  baseAddr;
  logic               isWrite;
  logic               advSeen;
  logic [DATA_W-1:0]  readData;
  logic               readValid;

  // Configuration decode.
  wire [BL_W-1:0]  cfgLen     = configWord[BL_LSB +: BL_W];              // R22
  wire             cfgIlv     = configWord[BT_BIT];
  wire [LAT_W-1:0] cfgLatRaw  = configWord[LAT_LSB +: LAT_W];
  wire             cfgWaitHi  = configWord[WP_BIT];
  wire             syncMode   = configWord[OM_LSB +: OM_W] == OM_SYNC;   // R23
  wire [LAT_W-1:0] cfgLat     = (cfgLatRaw < LAT_MIN) ? LAT_MIN : cfgLatRaw; // R10
  // Unlisted length codes fall back to four words.
  wire [7:0] lenMask = (cfgLen == BL_256) ? 8'hFF :
                       (cfgLen == BL_16)  ? 8'h0F :
                       (cfgLen == BL_8)   ? 8'h07 : 8'h03;               // R11
  wire       useIlv  = cfgIlv && (cfgLen != BL_256);                     // R21

  // A command needs a fresh valid low; held-low valid starts nothing new.
  wire cmdEdge = syncMode && !link.chipSelectN && !link.addressValidN
                 && !advSeen && state == IDLE;                           // R1 R4 R5 R7

  // Word address of the current beat within the aligned block.
  wire [7:0] linLow  = (startLow + beat) & lenMask;                      // R19
  wire [7:0] ilvLow  = (startLow ^ beat) & lenMask;                      // R20
  wire [7:0] wordLow = useIlv ? ilvLow : linLow;
  wire [ADDR_W-1:0] wordAddr = (baseAddr & ~{{(ADDR_W-8){1'b0}}, lenMask})
                               | {{(ADDR_W-8){1'b0}}, wordLow};
  wire [DEPTH_W-1:0] memIdx  = wordAddr[DEPTH_W-1:0];

  wire inData   = state == DATA;
  wire lastBeat = inData && (beat == lenMask);
  // Wait goes active in the cycle before each word, i.e. the last latency cycle onward.
  wire preData  = (state == LATENCY && latCount == 3'h1) || (inData && !lastBeat);

  assign link.waitIndicator = cfgWaitHi ? preData : !preData;            // R16 R17 R18
  assign link.memDataOut    = readData;
  assign link.memDataOe     = readValid;

  // Tracks whether the current valid low pulse was already used.
  always_ff @(posedge clock or negedge rst_n) begin                      // R9
    if (!rst_n) begin
      advSeen <= 1'b0;
    end else begin
      advSeen <= !link.addressValidN && !link.chipSelectN;
    end
  end

  // Burst sequencer; chip select high aborts any phase immediately.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= IDLE;
      latCount <= '0;
      beat     <= '0;
      startLow <= '0;
      baseAddr <= '0;
      isWrite  <= 1'b0;
    end else if (link.chipSelectN) begin
      state    <= IDLE;                                                  // R14
      beat     <= '0;
    end else begin
      case (state)
        IDLE: begin
          if (cmdEdge) begin
            baseAddr <= link.address;                                    // R1
            startLow <= link.address[7:0];
            isWrite  <= !link.writeEnableN;                              // R2
            latCount <= cfgLat - 3'h1;
            beat     <= '0;
            state    <= LATENCY;
          end
        end
        LATENCY: begin
          latCount <= latCount - 3'h1;
          if (latCount == 3'h1) begin
            state <= DATA;                                               // R6 R8
          end
        end
        DATA: begin
          beat <= beat + 8'h01;                                          // R13
          if (lastBeat) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Write words are taken from the bus at each data clock.
  always_ff @(posedge clock) begin
    if (inData && isWrite && !link.chipSelectN) begin
      mem[memIdx] <= link.dataBus;                                       // R8
    end
  end

  // Read words leave a flop; the output edge is the clock-to-data delay.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData  <= '0;
      readValid <= 1'b0;
    end else begin
      readValid <= inData && !isWrite && !link.chipSelectN;              // R6 R13
      readData  <= mem[memIdx];
    end
  end

endmodule // burst_memory

// ==== common/burst_pkg.sv ====
/*
  Constants shared by both ends of the synchronous burst memory link:
  configuration word fields, burst length and type codes, latency range,
  the wait polarity bit and the full-page burst time limit.
  Assumes a single 50 MHz clock for both ends.
*/
package burst_pkg;

  localparam int ADDR_W      = 23;
  localparam int DATA_W      = 16;
  localparam int CFG_W       = 18;

  // Configuration word layout.
  localparam int BL_LSB      = 5;
  localparam int BL_W        = 3;
  localparam int BT_BIT      = 8;
  localparam int LAT_LSB     = 9;
  localparam int LAT_W       = 3;
  localparam int WP_BIT      = 13;
  localparam int OM_LSB      = 14;
  localparam int OM_W        = 2;

  // Field encodings.
  localparam logic [BL_W-1:0] BL_4    = 3'h2;
  localparam logic [BL_W-1:0] BL_8    = 3'h3;
  localparam logic [BL_W-1:0] BL_16   = 3'h4;
  localparam logic [BL_W-1:0] BL_256  = 3'h7;
  localparam logic [OM_W-1:0] OM_SYNC = 2'h2;
  localparam logic            BT_LIN  = 1'h0;
  localparam logic            BT_ILV  = 1'h1;

  // Least usable latency count.
  localparam logic [LAT_W-1:0] LAT_MIN = 3'h2;

  // Full-page burst time limit and its cycle budget at the clock rate.
  localparam int CLK_MHZ        = 50;
  localparam int BURST_CYCLE_NS = 2500;
  localparam int BURST_CYCLES   = (BURST_CYCLE_NS * CLK_MHZ) / 1000;

  typedef enum logic [1:0] {IDLE, LATENCY, DATA} burst_state_e;

endpackage

// ==== common/burst_if.sv ====
/*
  Pin-level link between the memory controller and the burst memory.
  The data bus is two-way; the interface resolves it from the host enable alone.
*/
`timescale 1ns/1ps
interface burst_if;
  import burst_pkg::*;

  logic                chipSelectN;
  logic                addressValidN;
  logic                writeEnableN;
  logic [ADDR_W-1:0]   address;
  logic [DATA_W-1:0]   hostDataOut;
  logic                hostDataOe;
  logic [DATA_W-1:0]   memDataOut;
  logic                memDataOe;
  logic                waitIndicator;

  wire  [DATA_W-1:0]   dataBus = hostDataOe ? hostDataOut : memDataOut;

  modport memory (
    input  chipSelectN, addressValidN, writeEnableN, address, hostDataOut, dataBus,
    output memDataOut, memDataOe, waitIndicator
  );
  modport host (
    input  memDataOut, waitIndicator, dataBus,
    output chipSelectN, addressValidN, writeEnableN, address, hostDataOut, hostDataOe
  );
endinterface

// ==== hdl/burst_host.sv ====
/*
  Host end: a controller that issues one burst per request, drives the
  command pins, supplies write data and returns read data to its user.
  Assumes the same configuration word as the memory and one shared clock.
*/
`timescale 1ns/1ps
module burst_host (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [burst_pkg::CFG_W-1:0]  configWord,
  input  wire logic                        start,
  input  wire logic                        writeOp,
  input  wire logic [burst_pkg::ADDR_W-1:0] startAddr,
  input  wire logic [7:0]                  wordCount,
  input  wire logic [burst_pkg::DATA_W-1:0] writeData,
  output logic                             writeTake,
  output logic [burst_pkg::DATA_W-1:0]     readData,
  output logic                             readValid,
  output logic                             busy,
  burst_if.host                            link
);
  import burst_pkg::*;

  burst_state_e      state;
  logic [LAT_W-1:0]  latCount;
  logic [7:0]        left;
  logic              isWrite;
  logic              rdPend;

  wire [LAT_W-1:0] cfgLatRaw = configWord[LAT_LSB +: LAT_W];
  wire [LAT_W-1:0] cfgLat    = (cfgLatRaw < LAT_MIN) ? LAT_MIN : cfgLatRaw; // R10
  wire inData = state == DATA;

  // The select stays low through the burst; releasing it ends a short burst.
  assign link.chipSelectN   = (state == IDLE) && !start;                 // R3 R14
  assign link.addressValidN = !(state == IDLE && start);
  assign link.writeEnableN  = (state == IDLE) ? !writeOp : !isWrite;     // R2 R4 R7
  assign link.address       = startAddr;
  assign link.hostDataOut   = writeData;
  assign link.hostDataOe    = inData && isWrite;                         // R8
  assign writeTake          = inData && isWrite;
  assign busy               = state != IDLE;                             // R15

  // Command, latency and data phase sequencing.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= IDLE;
      latCount <= '0;
      left     <= '0;
      isWrite  <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          if (start) begin
            isWrite  <= writeOp;
            left     <= wordCount;
            latCount <= cfgLat - 3'h1;
            state    <= LATENCY;
          end
        end
        LATENCY: begin
          latCount <= latCount - 3'h1;
          if (latCount == 3'h1) begin
            state <= DATA;
          end
        end
        DATA: begin
          left <= left - 8'h01;
          if (left == 8'h00) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // The memory launches each read word in the cycle after its beat, so the
  // word is captured one edge later still; rdPend bridges that cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readData  <= '0;
      readValid <= 1'b0;
      rdPend    <= 1'b0;
    end else begin
      rdPend    <= inData && !isWrite;
      readValid <= rdPend;                                               // R13
      readData  <= link.memDataOut;
    end
  end

endmodule // burst_host

// ==== sim/burst_link_props.sv ====
/* Assertions on the burst link pins.
   Assumes one clock and the interface signals wired in by name. */
`timescale 1ns/1ps
module burst_link_props (
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic [burst_pkg::CFG_W-1:0] configWord,
  input wire logic                        chipSelectN,
  input wire logic                        addressValidN,
  input wire logic                        writeEnableN,
  input wire logic                        hostDataOe,
  input wire logic                        memDataOe,
  input wire logic                        waitIndicator
);
  import burst_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Decoded settings; the length table falls back to four words.
  wire logic [BL_W-1:0] bl       = configWord[BL_LSB+:BL_W];
  wire logic            waitOn   = waitIndicator == configWord[WP_BIT];
  wire logic            syncMode = configWord[OM_LSB+:OM_W] == OM_SYNC;
  wire logic [8:0]      lenWords = (bl == BL_8) ? 9'h008 : (bl == BL_16) ? 9'h010 :
                                   (bl == BL_256) ? 9'h100 : 9'h004;
  logic [8:0]           oeRun;
  logic                 lastWe;
  logic [7:0]           csRun;

  // Cycles the chip has stayed selected; held to the full-page time budget.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      csRun <= 8'h00;
    end else begin
      csRun <= chipSelectN ? 8'h00 : csRun + 8'h01;
    end
  end

  // Run length of driven read data and the direction of the last command.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oeRun  <= 9'h000;
      lastWe <= 1'b1;
    end else begin
      oeRun <= memDataOe ? oeRun + 9'h001 : 9'h000;
      if (!chipSelectN && !addressValidN) begin
        lastWe <= writeEnableN;
      end
    end
  end

  a_wait_before_data: assert property ($rose(memDataOe) |-> $past(waitOn) || $past(waitOn, 2))
    else $error("read data came without a prior wait");
  a_idle_wait_level: assert property (chipSelectN && $past(chipSelectN) && $past(chipSelectN, 2)
    |-> !waitOn)
    else $error("wait active while deselected");
  a_no_bus_fight: assert property (!(memDataOe && hostDataOe))
    else $error("both ends drive the data bus");
  a_stop_releases: assert property ($rose(chipSelectN) |-> ##2 !memDataOe)
    else $error("memory still drives after deselect");
  a_mode_gate: assert property (!syncMode && $past(!syncMode) |-> !memDataOe)
    else $error("burst data outside synchronous mode");
  a_length_bound: assert property (memDataOe |-> oeRun < lenWords)
    else $error("read burst longer than configured");
  a_read_drive_only: assert property (memDataOe |-> lastWe)
    else $error("memory drives during a write burst");
  a_select_first: assert property (!addressValidN |-> !chipSelectN)
    else $error("address valid without chip select");
  a_burst_time_cap: assert property (csRun < BURST_CYCLES)
    else $error("burst held selected beyond the cycle budget");

  cover property ($rose(memDataOe) && configWord[WP_BIT]);
  cover property ($rose(memDataOe) && !configWord[WP_BIT]);
  cover property ($rose(chipSelectN) && oeRun == 9'h001);
endmodule // burst_link_props

// ==== sim/psram_sync_burst_interface_tb_top.sv ====
/* Testbench: host and memory joined by the burst link, driven through the
   host user port. Assumes the package constants and one 50 MHz clock. */
`timescale 1ns/1ps
module psram_sync_burst_interface_tb_top;
  import burst_pkg::*;
  logic              clock;
  logic              rst_n;
  logic              start;
  logic              writeOp;
  logic              writeTake;
  logic              readValid;
  logic              busy;
  logic [CFG_W-1:0]  configWord;
  logic [ADDR_W-1:0] startAddr;
  logic [7:0]        wordCount;
  logic [DATA_W-1:0] writeData;
  logic [DATA_W-1:0] readData;
  logic [DATA_W-1:0] model [0:255];
  int                err_count = 0;
  int                checked = 0;
  int                ticks = 0;
  int                lat [0:3];

  burst_if link ();
  burst_memory burst_memory_inst (.clock(clock), .rst_n(rst_n), .configWord(configWord),
    .link(link.memory));
  burst_host burst_host_inst (.clock(clock), .rst_n(rst_n), .configWord(configWord),
    .start(start), .writeOp(writeOp), .startAddr(startAddr), .wordCount(wordCount),
    .writeData(writeData), .writeTake(writeTake), .readData(readData),
    .readValid(readValid), .busy(busy), .link(link.host));
  burst_link_props burst_link_props_inst (.clock(clock), .rst_n(rst_n),
    .configWord(configWord), .chipSelectN(link.chipSelectN),
    .addressValidN(link.addressValidN), .writeEnableN(link.writeEnableN),
    .hostDataOe(link.hostDataOe), .memDataOe(link.memDataOe),
    .waitIndicator(link.waitIndicator));

  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // A hang counts as a mismatch; the tests need well under this many cycles.
  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Word address of beat i within the aligned block.
  function automatic int addrAt(int s, int i, int len, logic ilv);
    return (s & ~(len - 1)) | ((ilv ? (s ^ i) : (s + i)) & (len - 1));
  endfunction

  task automatic setup(logic [BL_W-1:0] bl, logic bt, logic [2:0] l, logic wp, logic [1:0] om);
    @(posedge clock);
    configWord <= CFG_W'({om, wp, 1'b0, l, bt, bl, 5'h00});
  endtask

  // One burst; beats are sampled mid-cycle, data advanced at the next edge.
  task automatic burst(input logic wr, input int s, cnt, len, input logic ilv, chk,
                       input logic [DATA_W-1:0] base, output int first);
    int i;
    int t;
    int prev;
    i = 0;
    t = 0;
    prev = 0;
    first = 0;
    @(posedge clock);
    start     <= 1'b1;
    writeOp   <= wr;
    startAddr <= ADDR_W'(s);
    wordCount <= 8'(cnt);
    writeData <= base;
    @(posedge clock);
    start <= 1'b0;
    while (!((i > cnt || !chk) && busy === 1'b0)) begin
      @(negedge clock);
      t++;
      if ((wr ? writeTake : readValid) === 1'b1) begin
        if (i == 0) first = t;
        else check(16'(t - prev), 16'h0001);
        prev = t;
        if (wr) model[addrAt(s, i, len, ilv)] = writeData;
        else if (chk) check(readData, model[addrAt(s, i, len, ilv)]);
        i++;
        @(posedge clock);
        writeData <= base + DATA_W'(i);
      end
    end
  endtask

  // Main sequence: each step after the first reconfigures, then runs bursts.
  initial begin
    rst_n      = 1'b0;
    start      = 1'b0;
    writeOp    = 1'b0;
    startAddr  = '0;
    wordCount  = 8'h00;
    writeData  = '0;
    configWord = CFG_W'({OM_SYNC, 1'b1, 1'b0, 3'h3, BT_LIN, BL_4, 5'h00});
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    burst(1'b1, 0, 3, 4, BT_LIN, 1'b1, 16'hA000, lat[0]);
    burst(1'b0, 2, 3, 4, BT_LIN, 1'b1, 16'h0000, lat[1]);
    $display("test 1 done");
    setup(BL_4, BT_ILV, 3'h3, 1'b1, OM_SYNC);
    burst(1'b0, 3, 3, 4, BT_ILV, 1'b1, 16'h0000, lat[2]);
    $display("test 2 done");
    setup(BL_8, BT_ILV, 3'h5, 1'b0, OM_SYNC);
    burst(1'b1, 5, 7, 8, BT_ILV, 1'b1, 16'hB000, lat[2]);
    check(16'(lat[2] - lat[0]), 16'h0002);
    burst(1'b0, 5, 7, 8, BT_ILV, 1'b1, 16'h0000, lat[3]);
    check(16'(lat[3] - lat[1]), 16'h0002);
    $display("test 3 done");
    setup(BL_16, BT_LIN, 3'h2, 1'b1, OM_SYNC);
    burst(1'b1, 14, 15, 16, BT_LIN, 1'b1, 16'hC000, lat[0]);
    setup(BL_16, BT_ILV, 3'h2, 1'b1, OM_SYNC);
    burst(1'b0, 9, 15, 16, BT_ILV, 1'b1, 16'h0000, lat[0]);
    $display("test 4 done");
    setup(BL_8, BT_LIN, 3'h2, 1'b1, OM_SYNC);
    burst(1'b0, 6, 1, 8, BT_LIN, 1'b1, 16'h0000, lat[0]);
    burst(1'b0, 0, 7, 8, BT_LIN, 1'b1, 16'h0000, lat[0]);
    $display("test 5 done");
    setup(BL_4, BT_LIN, 3'h3, 1'b1, 2'h0);
    burst(1'b0, 0, 3, 4, BT_LIN, 1'b0, 16'h0000, lat[0]);
    $display("test 6 done");
    wrap_up();
  end
endmodule // psram_sync_burst_interface_tb_top
